// ===== hw/psl_pkg.sv
// shared constants and types for the power status indicator block
package psl_pkg;

    localparam int CLK_KHZ         = 20000;
    localparam int HALF_SEC_MS     = 500;
    localparam int HALF_SEC_CYC    = HALF_SEC_MS * CLK_KHZ;
    localparam int CNT_W           = 25;
    localparam int START_UNITS     = 4;
    localparam int ONE_UNITS       = 2;
    localparam int ZERO_UNITS      = 1;
    localparam int GAP_UNITS       = 1;
    localparam int CODE_BITS       = 8;

    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [2:0] HSIZE_WORD      = 3'h2;
    localparam int         CTRL_REPORT_BIT = 0;
    localparam int         CTRL_CODE_LSB   = 8;
    localparam int         STAT_CODE_LSB   = 8;
    localparam int         STAT_BAT_LSB    = 16;
    localparam int         STAT_DC_LSB     = 18;

    localparam int NUM_FAULTS = 35;
    localparam logic [7:0] FAULT_CODE [NUM_FAULTS] = '{
        8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
        8'h22, 8'h23, 8'h24, 8'h25,
        8'h32, 8'h33, 8'h34, 8'h35,
        8'h40, 8'h45, 8'h46,
        8'h50, 8'h51, 8'h52, 8'h54,
        8'h60, 8'h61, 8'h62, 8'h64,
        8'h70, 8'h71, 8'h72, 8'h73,
        8'h80, 8'h81, 8'h82, 8'h84,
        8'h90, 8'h91, 8'h92
    };

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_ON, SEQ_GAP} psl_seq_type;

    typedef struct packed {
        logic dc_present;
        logic charging;
        logic full_charged;
        logic sys_on;
        logic bat_low;
        logic bat_only;
        logic bat_present;
    } psl_power_type;

    typedef struct packed {
        logic green;
        logic orange;
    } psl_led_type;

    typedef struct packed {
        logic              ready;
        logic              wr_pend;
        logic [31:0]       rdata;
        logic              sw_report;
        logic [7:0]        sw_code;
        logic              fault_latched;
        logic [7:0]        fault_code;
        psl_seq_type       seq;
        logic [CNT_W-1:0]  seq_cyc;
        logic [2:0]        seq_units;
        logic [2:0]        bit_idx;
        logic [CNT_W-1:0]  bat_cyc;
        logic              bat_phase;
        logic [CNT_W-1:0]  oneshot_cnt;
        logic              prev_on;
        psl_led_type       bat_led;
        psl_led_type       dc_led;
    } psl_state_type;

endpackage

// ===== hw/psl_led_encoder.sv
// battery and dc input indicator driver with serial fault code blinker
//
// What this block does
// - charging with dc input: battery steady orange
// - full with dc input: battery steady green
// - power on, battery low: even orange blink
// - switch-on on battery, low: single orange blink
// - any other condition: indicator stays dark
// - dc input, no fault: dc indicator green
// - any fault: dc indicator blinks orange code
// - each code starts with two seconds off
// - eight-bit code sent lsb first
// - one is 1 s on, zero 0.5 s
// - half second off between data bits
// - upper nibble names the fault source
// - adapter faults map to 10h through 14h
// - main battery faults map to 22h-25h
// - second battery faults map to 32h-35h
// - standby 3v rail: 40h, 45h, 46h
// - always-on 5v rail: 50h-54h
// - always-on 3v rail: 60h-64h
// - always-on 1v5 rail: 70h-73h
// - backup 1v8 rail: 80h-84h
// - processor core rail: 90h, 91h, 92h
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module psl_led_encoder
    import psl_pkg::*;
#(
    parameter int unsigned HALF_SEC_CYCLES = HALF_SEC_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    input  wire psl_power_type         power,
    input  wire logic [NUM_FAULTS-1:0] fault_flags,
    output psl_led_type                bat_led,
    output psl_led_type                dc_led
);

    initial begin
        if (HALF_SEC_CYCLES < 1 || HALF_SEC_CYCLES > (2 ** (CNT_W - 1)) - 1) begin
            $error("HALF_SEC_CYCLES out of range");
        end
    end

    localparam logic [CNT_W-1:0] HALF_M1     = CNT_W'(HALF_SEC_CYCLES - 1);
    localparam logic [CNT_W-1:0] HALF_LEN    = CNT_W'(HALF_SEC_CYCLES);
    localparam logic [CNT_W-1:0] ONESHOT_LEN = CNT_W'(2 * HALF_SEC_CYCLES);

    psl_state_type s_reg;
    psl_state_type s_next;

    ////////////////////////////////////////////////////////////////////////////////
    // fault priority: lowest table entry wins
    function automatic logic [8:0] pick_fault(input logic [NUM_FAULTS-1:0] flags);
        logic [8:0] res;
        res = 9'h000;
        for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
            if (flags[i]) begin
                res = {1'b1, FAULT_CODE[i]};
            end
        end
        return res;
    endfunction

    function automatic logic [2:0] bit_units(input logic b);
        return b ? 3'(ONE_UNITS - 1) : 3'(ZERO_UNITS - 1);
    endfunction

    logic [8:0] hw_fault;
    assign hw_fault = pick_fault(fault_flags);

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic unit_end;
        logic power_gone;
        s_next = s_reg;
        unit_end = 1'b0;
        power_gone = !power.dc_present && !power.bat_present;

        // bus slave, zero wait states
        s_next.ready = 1'b1;
        s_next.sw_report = 1'b0;
        if (s_reg.wr_pend) begin
            s_next.sw_code = hwdata[CTRL_CODE_LSB +: 8];
            s_next.sw_report = hwdata[CTRL_REPORT_BIT];
        end
        s_next.wr_pend = 1'b0;
        s_next.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && hsize == HSIZE_WORD) begin
            s_next.wr_pend = hwrite && haddr[7:0] == ADDR_CTRL;
            if (!hwrite) begin
                case (haddr[7:0])
                    ADDR_CTRL: begin
                        s_next.rdata[CTRL_CODE_LSB +: 8] = s_reg.sw_code;
                    end
                    ADDR_STATUS: begin
                        s_next.rdata[0] = s_reg.fault_latched;
                        s_next.rdata[STAT_CODE_LSB +: 8] = s_reg.fault_code;
                        s_next.rdata[STAT_BAT_LSB +: 2] = s_reg.bat_led;
                        s_next.rdata[STAT_DC_LSB +: 2] = s_reg.dc_led;
                    end
                    default: begin
                        s_next.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // free running half-second base for the battery blink
        if (s_reg.bat_cyc == HALF_M1) begin
            s_next.bat_cyc = '0;
            s_next.bat_phase = !s_reg.bat_phase;
        end else begin
            s_next.bat_cyc = s_reg.bat_cyc + 1'b1;
        end

        // single blink at switch-on from battery alone
        s_next.prev_on = power.sys_on;
        if (s_reg.oneshot_cnt != '0) begin
            s_next.oneshot_cnt = s_reg.oneshot_cnt - 1'b1;
        end
        // switch-off cuts a pending single blink so the indicator goes dark
        if (!power.sys_on) begin
            s_next.oneshot_cnt = '0;
        end
        if (power.sys_on && !s_reg.prev_on && power.bat_only && power.bat_low) begin
            s_next.oneshot_cnt = ONESHOT_LEN;
        end

        // serial code sequencer
        case (s_reg.seq)
            SEQ_START: begin
                unit_end = s_reg.seq_cyc == HALF_M1;
                if (unit_end && s_reg.seq_units == 3'(START_UNITS - 1)) begin
                    s_next.seq = SEQ_ON;
                    s_next.bit_idx = '0;
                end
            end
            SEQ_ON: begin
                unit_end = s_reg.seq_cyc == HALF_M1;
                if (unit_end && s_reg.seq_units == bit_units(s_reg.fault_code[s_reg.bit_idx])) begin
                    s_next.seq = (s_reg.bit_idx == 3'(CODE_BITS - 1)) ? SEQ_START : SEQ_GAP;
                end
            end
            SEQ_GAP: begin
                unit_end = s_reg.seq_cyc == HALF_M1;
                if (unit_end && s_reg.seq_units == 3'(GAP_UNITS - 1)) begin
                    s_next.seq = SEQ_ON;
                    s_next.bit_idx = s_reg.bit_idx + 1'b1;
                end
            end
            default: begin
                unit_end = 1'b0;
            end
        endcase
        if (s_next.seq != s_reg.seq) begin
            s_next.seq_cyc = '0;
            s_next.seq_units = '0;
        end else if (unit_end) begin
            s_next.seq_cyc = '0;
            s_next.seq_units = s_reg.seq_units + 1'b1;
        end else if (s_reg.seq != SEQ_IDLE) begin
            s_next.seq_cyc = s_reg.seq_cyc + 1'b1;
        end

        // fault latch: held until every source of power is gone
        if (power_gone) begin
            s_next.fault_latched = 1'b0;
            s_next.seq = SEQ_IDLE;
            s_next.seq_cyc = '0;
            s_next.seq_units = '0;
        end else if (!s_reg.fault_latched && (hw_fault[8] || s_reg.sw_report)) begin
            s_next.fault_latched = 1'b1;
            s_next.fault_code = hw_fault[8] ? hw_fault[7:0] : s_reg.sw_code;
            s_next.seq = SEQ_START;
            s_next.seq_cyc = '0;
            s_next.seq_units = '0;
        end

        // indicator outputs follow the next state so they line up with it
        s_next.dc_led = '0;
        if (s_next.fault_latched) begin
            s_next.dc_led.orange = s_next.seq == SEQ_ON;
        end else if (power.dc_present) begin
            s_next.dc_led.green = 1'b1;
        end
        s_next.bat_led = '0;
        if (power.dc_present && power.charging) begin
            s_next.bat_led.orange = 1'b1;
        end else if (power.dc_present && power.full_charged) begin
            s_next.bat_led.green = 1'b1;
        end else if (s_next.oneshot_cnt != '0) begin
            s_next.bat_led.orange = s_next.oneshot_cnt > HALF_LEN;
        end else if (power.sys_on && power.bat_low) begin
            s_next.bat_led.orange = s_next.bat_phase;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign hreadyout = s_reg.ready;
    assign hrdata    = s_reg.rdata;
    assign hresp     = 1'b0;
    assign bat_led   = s_reg.bat_led;
    assign dc_led    = s_reg.dc_led;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    int phase_len;
    always_ff @(posedge clk) begin
        if (!rst_n || s_next.seq != s_reg.seq) begin
            phase_len <= 0;
        end else begin
            phase_len <= phase_len + 1;
        end
    end

    localparam int START_LEN = START_UNITS * HALF_SEC_CYCLES;
    localparam int ONE_LEN   = ONE_UNITS * HALF_SEC_CYCLES;
    localparam int ZERO_LEN  = ZERO_UNITS * HALF_SEC_CYCLES;
    localparam int GAP_LEN   = GAP_UNITS * HALF_SEC_CYCLES;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_leave_start;
        s_reg.seq == SEQ_START ##1 s_reg.seq == SEQ_ON;
    endsequence
    sequence s_leave_on;
        s_reg.seq == SEQ_ON ##1 s_reg.seq != SEQ_ON && s_reg.fault_latched;
    endsequence

    property p_bat_charging;
        power.dc_present && power.charging |=> bat_led.orange && !bat_led.green;
    endproperty
    a_bat_charging: assert property (p_bat_charging) else $error("battery not orange while charging");

    property p_bat_full;
        power.dc_present && power.full_charged && !power.charging |=> bat_led.green && !bat_led.orange;
    endproperty
    a_bat_full: assert property (p_bat_full) else $error("battery not green when full");

    property p_dark;
        !power.sys_on && !power.dc_present |=> bat_led == '0;
    endproperty
    a_dark: assert property (p_dark) else $error("battery indicator lit without cause");

    property p_dc_green;
        power.dc_present && !s_next.fault_latched |=> dc_led.green && !dc_led.orange;
    endproperty
    a_dc_green: assert property (p_dc_green) else $error("dc indicator not green");

    property p_fault_no_green;
        s_reg.fault_latched |-> !dc_led.green && dc_led.orange == (s_reg.seq == SEQ_ON);
    endproperty
    a_fault_no_green: assert property (p_fault_no_green) else $error("dc indicator wrong during fault");

    logic bit_idx_zero;
    assign bit_idx_zero = s_reg.bit_idx == 3'h0;
    property p_start_len;
        s_leave_start |-> $past(phase_len) == START_LEN - 1 && bit_idx_zero;
    endproperty
    a_start_len: assert property (p_start_len) else $error("start interval wrong length");

    property p_bit_len;
        s_leave_on |-> $past(phase_len) == ($past(s_reg.fault_code[s_reg.bit_idx]) ? ONE_LEN - 1 : ZERO_LEN - 1);
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("bit pulse wrong length");

    property p_bit_order;
        s_reg.seq == SEQ_ON && s_next.seq == SEQ_START |-> s_reg.bit_idx == 3'(CODE_BITS - 1);
    endproperty
    a_bit_order: assert property (p_bit_order) else $error("code ended before msb");

    property p_gap;
        s_reg.seq == SEQ_GAP && s_next.seq == SEQ_ON |-> phase_len == GAP_LEN - 1 && !dc_led.orange;
    endproperty
    a_gap: assert property (p_gap) else $error("gap between bits wrong");

    property p_hold;
        s_reg.fault_latched && (power.dc_present || power.bat_present) |=> s_reg.fault_latched && $stable(s_reg.fault_code);
    endproperty
    a_hold: assert property (p_hold) else $error("fault dropped while powered");

endmodule
`default_nettype wire

// ===== tb/psl_led_viewer.sv
// technician model: decodes the dc indicator blink pattern into a code
`timescale 1ns/100ps
`default_nettype none
module psl_led_viewer
    import psl_pkg::*;
#(
    parameter int HALF = 4
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire psl_led_type dc_led,
    output logic [7:0]       code,
    output logic [7:0]       frames,
    output logic [7:0]       err_cnt
);
    int         on_len;
    int         off_len;
    logic [2:0] idx;
    logic       in_frame;
    logic [7:0] shreg;

    always @(posedge clk) begin
        if (!rst_n) begin
            on_len = 0;
            off_len = 0;
            in_frame = 0;
            idx = 0;
            shreg = 0;
            code <= 8'h00;
            frames <= 8'h00;
            err_cnt <= 8'h00;
        end else if (dc_led.green) begin
            on_len = 0;
            off_len = 0;
            in_frame = 0;
        end else if (dc_led.orange) begin
            if (on_len == 0) begin
                if (off_len == START_UNITS * HALF) begin
                    in_frame = 1;
                    idx = 0;
                end else if (in_frame && idx != 0 && off_len != GAP_UNITS * HALF) begin
                    err_cnt <= err_cnt + 8'h01;
                    in_frame = 0;
                end
            end
            on_len++;
            off_len = 0;
        end else begin
            if (on_len != 0 && in_frame) begin
                if (on_len == ONE_UNITS * HALF) shreg[idx] = 1'b1;
                else if (on_len == ZERO_UNITS * HALF) shreg[idx] = 1'b0;
                else begin
                    err_cnt <= err_cnt + 8'h01;
                    in_frame = 0;
                end
                if (in_frame && idx == 3'h7) begin
                    code <= shreg;
                    frames <= frames + 8'h01;
                end
                idx = idx + 3'h1;
            end
            on_len = 0;
            off_len++;
        end
    end
endmodule
`default_nettype wire

// ===== tb/psl_led_encoder_test.sv
// self-checking bench for the power status indicator block
`timescale 1ns/100ps
`default_nettype none
module psl_led_encoder_test;
    import psl_pkg::*;
    localparam int H = 4;
    localparam logic [7:0] EXP [35] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h22, 8'h23, 8'h24, 8'h25,
        8'h32, 8'h33, 8'h34, 8'h35, 8'h40, 8'h45, 8'h46, 8'h50, 8'h51, 8'h52, 8'h54, 8'h60, 8'h61,
        8'h62, 8'h64, 8'h70, 8'h71, 8'h72, 8'h73, 8'h80, 8'h81, 8'h82, 8'h84, 8'h90, 8'h91, 8'h92};
    localparam logic [6:0] PW [5] = '{7'h61, 7'h69, 7'h51, 7'h09, 7'h41};
    localparam logic [3:0] LD [5] = '{4'h6, 4'h6, 4'hA, 4'h0, 4'h2};
    logic                  clk;
    logic                  rst_n;
    logic                  hsel;
    logic [31:0]           haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [2:0]            hsize;
    logic [31:0]           hwdata;
    logic                  hreadyout;
    logic [31:0]           hrdata;
    logic                  hresp;
    psl_power_type         power;
    logic [NUM_FAULTS-1:0] fault_flags;
    psl_led_type           bat_led;
    psl_led_type           dc_led;
    logic [7:0]            code;
    logic [7:0]            frames;
    logic [7:0]            err_cnt;
    logic [63:0]           seed;
    logic [31:0]           rd;
    int                    n_mismatch;
    int                    cmp_count;
    int                    cnt;

    psl_led_encoder #(.HALF_SEC_CYCLES(H)) u_psl_led_encoder (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .power(power),
        .fault_flags(fault_flags), .bat_led(bat_led), .dc_led(dc_led));
    psl_led_viewer #(.HALF(H)) u_psl_led_viewer (.clk(clk), .rst_n(rst_n), .dc_led(dc_led),
        .code(code), .frames(frames), .err_cnt(err_cnt));

    function automatic logic [63:0] xs(input logic [63:0] s);
        s ^= s << 13;
        s ^= s >> 7;
        s ^= s << 17;
        return s;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wait_frame;
        logic [7:0] n;
        int k;
        n = frames;
        k = 0;
        while (frames === n && k < 400) begin
            @(posedge clk);
            k++;
        end
        if (frames === n) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, frames, n + 8'h01);
        end
    endtask

    task automatic tally_and_finish;
        $display("n_mismatch=%0d cmp_count=%0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        {rst_n, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
        power = '0;
        fault_flags = '0;
        seed = 64'h3D;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        ahb(1'b0, {24'h0, ADDR_STATUS}, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        ahb(1'b0, 32'h0000_0008, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b1, {24'h0, ADDR_CTRL}, 32'h0000_5A00);
        ahb(1'b0, {24'h0, ADDR_CTRL}, 32'h0);
        chk(rd, 32'h0000_5A00);
        for (int c = 0; c < 5; c++) begin
            power <= PW[c];
            repeat (3) @(posedge clk);
            chk({bat_led, dc_led}, LD[c]);
        end
        power <= 7'h0D;
        repeat (3) @(posedge clk);
        cnt = 0;
        repeat (4 * H) begin
            @(posedge clk);
            cnt += bat_led.orange;
        end
        chk(cnt, 2 * H);
        power <= 7'h07;
        repeat (5) @(posedge clk);
        power <= 7'h0F;
        repeat (2) @(posedge clk);
        chk(bat_led, 2'b01);
        cnt = 0;
        repeat (2 * H) begin
            cnt += bat_led.orange;
            @(posedge clk);
        end
        chk(cnt, H);
        for (int i = 0; i < NUM_FAULTS; i++) begin
            power <= 7'h41;
            repeat (2) @(posedge clk);
            seed = xs(seed);
            fault_flags <= (35'h1 << i) | (seed[34:0] & ~((35'h1 << (i + 1)) - 35'h1));
            wait_frame();
            chk(code, EXP[i]);
            fault_flags <= seed[63:29];
            wait_frame();
            chk(code, EXP[i]);
            ahb(1'b0, {24'h0, ADDR_STATUS}, 32'h0);
            chk(rd & 32'h0000_FF01, {16'h0, EXP[i], 8'h01});
            fault_flags <= '0;
            power <= 7'h00;
            repeat (3) @(posedge clk);
            chk(dc_led, 2'b00);
        end
        power <= 7'h41;
        repeat (2) @(posedge clk);
        ahb(1'b1, {24'h0, ADDR_CTRL}, 32'h0000_A501);
        wait_frame();
        chk(code, 8'hA5);
        chk(err_cnt, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
